// file: verilog/pmsc_top.sv
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
// Function
// - Volatile registers reset to fixed constants; writes lost on power cycle.
// - Factory-class registers reset to parameter defaults each power cycle.
// - Cold state waits for supply window, registers held at defaults.
// - Supply inside window leaves cold state toward sequence start.
// - Supply below lockout returns any state to cold, restoring registers.
// - Four three-level straps sampled before sequence start.
// - Straps give buck1 V/bypass, buck3 3 V, buck4 V/LDO, LDO1 V/bypass.
// - Buck two voltage set from a two-level GPIO.
// - LDO two regulator when its GPIO high, load switch when low.
// - One GPIO strap sets extra power-up delay of buck4, LDO1, LDO2.
// - Strap-assigned three-level GPIOs refuse host reassignment.
// - Straps sampled once at power-up, then latched.
// - Host may change voltages and low-power pattern; reset restores them.
// - Host may reassign free GPIOs; reset restores defaults.
// - Sequence start enables outputs, leaves once all are in regulation.
// - Fault masks forced to one during startup, cleared after success.
// - Active entered from sequence start with supply valid and no fault, or from sleep, deep sleep or fault retry.
// - Sleep applies per-output on/off and buck three choice.
// - Combine select 0: AND entry, exit as soon as any input drops.
// - Combine select 1: OR entry, exit only when all inputs drop.
// - Deep sleep has its own per-output and buck three settings.
// - Deep sleep uses its own combine select in the same way.
// - Serial interface machine reset on entering cold or fault-retry state.
// - Output OV/UV after start shuts rails, asserts reset, retries later.
module pmsc_top
	import pmsc_pkg::*;
#(
	parameter int           RETRY_CYCLES = RETRY_CYC,
	parameter logic [3:0]   STRAP_MASK   = 4'b1111,
	parameter int           B2_GPIO      = 0,
	parameter int           L2_GPIO      = 5,
	parameter int           DLY_GPIO     = 6,
	parameter logic         SCOMB_DEF    = 1'b0,
	parameter logic         DCOMB_DEF    = 1'b0,
	parameter logic [7:0]   SLP_CFG_DEF  = 8'h3F,
	parameter logic [7:0]   DSLP_CFG_DEF = 8'h81
) (
	input  wire logic              mclk_i,
	input  wire logic              rstn_i,
	input  wire logic              vin_above_undervoltage_lockout_threshold_i,
	input  wire logic              vin_below_ov_i,
	input  wire logic [NOUT-1:0]   out_in_reg_i,
	input  wire logic [NOUT-1:0]   out_ovuv_i,
	input  wire logic [NGPIO-1:0]  gpio_i,
	input  wire logic [2*NTRI-1:0] strap_lvl_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic [DATA_W-1:0]      rdata_o,
	output logic [NOUT-1:0]        out_en_o,
	output logic [1:0]             b3_sel_o,
	output logic                   b3_scale_o,
	output logic [DATA_W-1:0]      vsel_o,
	output logic                   buck1_bypass_o,
	output logic                   buck4_ldo_o,
	output logic                   ldo1_bypass_o,
	output logic                   ldo2_switch_o,
	output logic                   extra_delay_o,
	output logic [3:0]             fault_mask_o,
	output logic                   system_reset_n_o,
	output logic                   serial_reset_o,
	output logic [2:0]             state_o
);

	// Derived widths: the synchroniser vector and the dwell counter.
	localparam int SW = 2 * NOUT + NGPIO + 2 * NTRI + 2;
	localparam int CW = $clog2(RETRY_CYCLES + 1);
	localparam logic [CW-1:0] RETRY_LAST = CW'(RETRY_CYCLES - 1);
	localparam logic [CW-1:0] CNT_ZERO   = '0;
	// Three-level pins 1..4 of the GPIO bank carry the straps.
	localparam logic [NGPIO-1:0] LOCK = {3'b000, STRAP_MASK, 1'b0};

	// Two-flop synchroniser on every asynchronous status input.
	// Trade-off: two cycles of latency on every status input buy freedom
	// from metastability on pins that move with no relation to the clock.
	logic [SW-1:0] sync_a;
	logic [SW-1:0] sync_b;
	wire  [SW-1:0] raw_in = {vin_above_undervoltage_lockout_threshold_i, vin_below_ov_i, out_in_reg_i,
		out_ovuv_i, gpio_i, strap_lvl_i};

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
		end
	end

	// Unpack the synchronised vector in the order it was packed.
	wire              s_undervoltage_lockout_threshold_ok = sync_b[SW-1];
	wire              s_ov_ok   = sync_b[SW-2];
	wire [NOUT-1:0]   s_in_reg  = sync_b[SW-3 -: NOUT];
	wire [NOUT-1:0]   s_ovuv    = sync_b[SW-3-NOUT -: NOUT];
	wire [NGPIO-1:0]  s_gpio    = sync_b[2*NTRI +: NGPIO];
	wire [2*NTRI-1:0] s_strap   = sync_b[2*NTRI-1:0];

	// Registers and state.
	pmsc_state_t     state;
	pmsc_state_t     next_state;
	logic [7:0]      ctrl;
	logic [7:0]      slp_cfg;
	logic [7:0]      dslp_cfg;
	logic [7:0]      slp_gpio;
	logic [7:0]      dslp_gpio;
	logic [7:0]      vout;
	logic [7:0]      strap_q;
	logic            strap_done;
	logic [CW-1:0]   retry_cnt;

	// Supply conditions and the window test.
	wire vin_valid = s_undervoltage_lockout_threshold_ok & s_ov_ok;
	wire undervoltage_lockout_threshold_drop = ~s_undervoltage_lockout_threshold_ok & (state != PMSC_COLD);
	wire all_reg   = &s_in_reg;
	wire any_ovuv  = |s_ovuv;

	// Low-power request combining; an empty assignment leaves the bit alone.
	wire s_all  = &(s_gpio | ~slp_gpio);
	wire s_any  = |(s_gpio & slp_gpio);
	wire d_all  = &(s_gpio | ~dslp_gpio);
	wire d_any  = |(s_gpio & dslp_gpio);
	wire s_and  = ctrl[CTRL_SLEEP] & s_all;
	wire s_or   = ctrl[CTRL_SLEEP] | s_any;
	wire d_and  = ctrl[CTRL_DEEP] & d_all;
	wire d_or   = ctrl[CTRL_DEEP] | d_any;
	wire sleep_req = ctrl[CTRL_SCOMB] ? s_or : s_and;
	wire deep_req  = ctrl[CTRL_DCOMB] ? d_or : d_and;

	// Low-power target; deep sleep outranks sleep when both are requested.
	// Exit needs no extra logic: once the combined request falls, the
	// target drops back to active on the next edge.
	pmsc_state_t lp_target;
	assign lp_target = deep_req  ? PMSC_DEEP :
		(sleep_req ? PMSC_SLEEP : PMSC_ACTIVE);

	// Fault retry only arms once startup masks are released.
	wire ovuv_trip = any_ovuv & ~fault_mask_o[0];

	// Next-state logic.
	// A supply drop overrides every branch, so it is applied last.
	always_comb begin
		next_state = state;
		case (state)
			PMSC_COLD: begin
				if (vin_valid) begin
					next_state = PMSC_STRAP;
				end
			end
			PMSC_STRAP: begin
				next_state = PMSC_SEQ;
			end
			PMSC_SEQ: begin
				if (vin_valid && all_reg && !any_ovuv) begin
					next_state = lp_target;
				end
			end
			PMSC_ACTIVE, PMSC_SLEEP, PMSC_DEEP: begin
				if (ovuv_trip) begin
					next_state = PMSC_FAULT;
				end else begin
					next_state = lp_target;
				end
			end
			PMSC_FAULT: begin
				if (retry_cnt == RETRY_LAST) begin
					next_state = PMSC_ACTIVE;
				end
			end
			default: begin
				next_state = PMSC_COLD;
			end
		endcase
		if (undervoltage_lockout_threshold_drop) begin
			next_state = PMSC_COLD;
		end
	end

	// State register and fault dwell counter.
	// The counter restarts whenever the state leaves fault retry, so a
	// supply drop in the middle of a retry never leaves a stale count.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state     <= PMSC_COLD;
			retry_cnt <= CNT_ZERO;
		end else begin
			state     <= next_state;
			retry_cnt <= (state == PMSC_FAULT && next_state == PMSC_FAULT) ?
				retry_cnt + 1'b1 : CNT_ZERO;
		end
	end

	// Strap decode of the sampled levels.
	wire [1:0] lv_b1 = s_strap[1:0];
	wire [1:0] lv_b3 = s_strap[3:2];
	wire [1:0] lv_b4 = s_strap[5:4];
	wire [1:0] lv_l1 = s_strap[7:6];
	wire [7:0] strap_vout;
	assign strap_vout[VO_B1]      = (lv_b1 == LVL_HIGH);
	assign strap_vout[VO_B2]      = ~s_gpio[B2_GPIO];
	assign strap_vout[VO_B3 +: 2] = lv_b3;
	assign strap_vout[VO_B4]      = (lv_b4 == LVL_HIGH);
	assign strap_vout[VO_L1]      = (lv_l1 == LVL_HIGH);
	assign strap_vout[7:6]        = 2'b00;

	// Strap latch: taken once per power-up, frozen until cold reset.
	// The done flag guards against a second capture should the state ever
	// linger in strap; only a return to cold rearms it.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strap_q        <= ZERO_BYTE;
			strap_done     <= 1'b0;
			buck1_bypass_o <= 1'b0;
			buck4_ldo_o    <= 1'b0;
			ldo1_bypass_o  <= 1'b0;
			ldo2_switch_o  <= 1'b0;
			extra_delay_o  <= 1'b0;
		end else if (next_state == PMSC_COLD) begin
			strap_done <= 1'b0;
		end else if (state == PMSC_STRAP && !strap_done) begin
			strap_q        <= s_strap;
			strap_done     <= 1'b1;
			buck1_bypass_o <= STRAP_MASK[0] & (lv_b1 == LVL_MID);
			buck4_ldo_o    <= STRAP_MASK[2] & (lv_b4 == LVL_MID);
			ldo1_bypass_o  <= STRAP_MASK[3] & (lv_l1 == LVL_MID);
			ldo2_switch_o  <= ~s_gpio[L2_GPIO];
			extra_delay_o  <= s_gpio[DLY_GPIO];
		end
	end

	// Register decode.
	// Writes are decoded by exact offset; unmapped offsets fall through
	// and are simply ignored.
	wire wr_ctrl  = wr_i & (addr_i == OFS_CTRL);
	wire wr_scfg  = wr_i & (addr_i == OFS_SLP_CFG);
	wire wr_dcfg  = wr_i & (addr_i == OFS_DSLP_CFG);
	wire wr_sgp   = wr_i & (addr_i == OFS_SLP_GPIO);
	wire wr_dgp   = wr_i & (addr_i == OFS_DSLP_GPIO);
	wire wr_vout  = wr_i & (addr_i == OFS_VOUT);
	wire reg_init = (state == PMSC_COLD);
	wire [7:0] ctrl_def = {4'h0, DCOMB_DEF, SCOMB_DEF, 2'b00};

	// Register file: any return to cold restores every default, so nothing
	// the host wrote survives a supply cycle.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl      <= {4'h0, DCOMB_DEF, SCOMB_DEF, 2'b00};
			slp_cfg   <= SLP_CFG_DEF;
			dslp_cfg  <= DSLP_CFG_DEF;
			slp_gpio  <= ZERO_BYTE;
			dslp_gpio <= ZERO_BYTE;
			vout      <= ZERO_BYTE;
		end else if (reg_init || undervoltage_lockout_threshold_drop) begin
			ctrl      <= ctrl_def;
			slp_cfg   <= SLP_CFG_DEF;
			dslp_cfg  <= DSLP_CFG_DEF;
			slp_gpio  <= ZERO_BYTE;
			dslp_gpio <= ZERO_BYTE;
			vout      <= ZERO_BYTE;
		end else begin
			if (state == PMSC_STRAP) begin
				vout <= strap_vout;
			end else if (wr_vout) begin
				vout <= wdata_i;
			end
			if (wr_ctrl) begin
				ctrl <= wdata_i;
			end
			if (wr_scfg) begin
				slp_cfg <= wdata_i;
			end
			if (wr_dcfg) begin
				dslp_cfg <= wdata_i;
			end
			if (wr_sgp) begin
				slp_gpio <= wdata_i & ~LOCK;
			end
			if (wr_dgp) begin
				dslp_gpio <= wdata_i & ~LOCK;
			end
		end
	end

	// Read mux; unmapped offsets read as zero.
	// The mux follows the address combinationally; only the registered
	// copy reaches the pin, so the port never shows a glitch.
	wire [7:0] status = {fault_mask_o, strap_done, state_o};
	logic [7:0] rd_mux;
	always_comb begin
		case (addr_i)
			OFS_CTRL:      rd_mux = ctrl;
			OFS_SLP_CFG:   rd_mux = slp_cfg;
			OFS_DSLP_CFG:  rd_mux = dslp_cfg;
			OFS_SLP_GPIO:  rd_mux = slp_gpio;
			OFS_DSLP_GPIO: rd_mux = dslp_gpio;
			OFS_VOUT:      rd_mux = vout;
			OFS_STATUS:    rd_mux = status;
			OFS_STRAP:     rd_mux = strap_q;
			default:       rd_mux = ZERO_BYTE;
		endcase
	end

	// Read data stand for exactly the cycle after the read strobe.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= ZERO_BYTE;
		end else begin
			rdata_o <= rd_i ? rd_mux : ZERO_BYTE;
		end
	end

	// Output pattern per next state; the analog sequencer applies the
	// per-output on and off delays, so enables here are plain levels.
	logic [NOUT-1:0] next_en;
	logic [1:0]      next_b3;
	always_comb begin
		next_en = '0;
		next_b3 = B3_STRAP;
		case (next_state)
			PMSC_SEQ, PMSC_ACTIVE: begin
				next_en = '1;
			end
			PMSC_SLEEP: begin
				next_en = slp_cfg[CFG_EN_LSB +: NOUT];
				next_b3 = slp_cfg[CFG_B3_LSB +: 2];
			end
			PMSC_DEEP: begin
				next_en = dslp_cfg[CFG_EN_LSB +: NOUT];
				next_b3 = dslp_cfg[CFG_B3_LSB +: 2];
			end
			default: begin
				next_en = '0;
			end
		endcase
		if (next_b3 == B3_OFF) begin
			next_en[2] = 1'b0;
		end
	end

	// Entering cold or fault-retry pulses the serial reset for one cycle.
	wire enter_clr = (next_state != state) &&
		(next_state == PMSC_COLD || next_state == PMSC_FAULT);
	wire next_masks_on = (next_state == PMSC_COLD) ||
		(next_state == PMSC_STRAP) || (next_state == PMSC_SEQ);

	// Registered outputs.
	// Every output except b3_sel_o and vsel_o, which follow vout, is taken
	// from next_state so that the state code and
	// the levels it implies change on the same edge.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			out_en_o         <= '0;
			b3_sel_o         <= 2'b00;
			b3_scale_o       <= 1'b0;
			vsel_o           <= ZERO_BYTE;
			fault_mask_o     <= 4'hF;
			system_reset_n_o <= 1'b0;
			serial_reset_o   <= 1'b0;
			state_o          <= PMSC_COLD;
		end else begin
			out_en_o         <= next_en;
			b3_scale_o       <= (next_b3 == B3_SCALE);
			b3_sel_o         <= vout[VO_B3 +: 2];
			vsel_o           <= vout;
			fault_mask_o     <= {4{next_masks_on}};
			system_reset_n_o <= (next_state == PMSC_ACTIVE) ||
				(next_state == PMSC_SLEEP) || (next_state == PMSC_DEEP);
			serial_reset_o   <= enter_clr;
			state_o          <= next_state;
		end
	end

endmodule

// file: common/pmsc_pkg.sv
package pmsc_pkg;

	// Widths of the register port and of the controlled resources.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NOUT   = 6;
	localparam int NGPIO  = 8;
	localparam int NTRI   = 4;

	// Register offsets.
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_SLP_CFG   = 8'h01;
	localparam logic [7:0] OFS_DSLP_CFG  = 8'h02;
	localparam logic [7:0] OFS_SLP_GPIO  = 8'h03;
	localparam logic [7:0] OFS_DSLP_GPIO = 8'h04;
	localparam logic [7:0] OFS_VOUT      = 8'h05;
	localparam logic [7:0] OFS_STATUS    = 8'h06;
	localparam logic [7:0] OFS_STRAP     = 8'h07;

	// Control register fields.
	localparam int CTRL_SLEEP = 0;
	localparam int CTRL_DEEP  = 1;
	localparam int CTRL_SCOMB = 2;
	localparam int CTRL_DCOMB = 3;

	// Low-power configuration fields: per-output enables, buck three mode.
	localparam int CFG_EN_LSB = 0;
	localparam int CFG_B3_LSB = 6;

	// Voltage select fields.
	localparam int VO_B1 = 0;
	localparam int VO_B2 = 1;
	localparam int VO_B3 = 2;
	localparam int VO_B4 = 4;
	localparam int VO_L1 = 5;

	// Status fields.
	localparam int ST_STATE_LSB = 0;
	localparam int ST_DONE      = 3;
	localparam int ST_MASK_LSB  = 4;

	// Fixed volatile reset value.
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// Levels reported by a three-level strap comparator.
	localparam logic [1:0] LVL_LOW  = 2'h0;
	localparam logic [1:0] LVL_MID  = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;

	// Buck three choice inside a low-power state.
	localparam logic [1:0] B3_STRAP = 2'h0;
	localparam logic [1:0] B3_SCALE = 2'h1;
	localparam logic [1:0] B3_OFF   = 2'h2;

	// Fault-retry dwell time.
	localparam int RETRY_MS  = 200;
	localparam int CLK_KHZ   = 250000;
	localparam int RETRY_CYC = RETRY_MS * CLK_KHZ;

	// Power states.
	typedef enum logic [2:0] {
		PMSC_COLD   = 3'b000,
		PMSC_STRAP  = 3'b001,
		PMSC_SEQ    = 3'b010,
		PMSC_ACTIVE = 3'b011,
		PMSC_SLEEP  = 3'b100,
		PMSC_DEEP   = 3'b101,
		PMSC_FAULT  = 3'b110
	} pmsc_state_t;

endpackage

// file: tb/pmsc_rail_model.sv
`timescale 1ns/100ps
// Rail stage: an enabled output reports regulation after a soft start,
// short or long by slow_i; a disabled output drops at once.
module pmsc_rail_model
	import pmsc_pkg::*;
(
	input  wire logic            mclk_i,
	input  wire logic            rstn_i,
	input  wire logic            slow_i,
	input  wire logic [NOUT-1:0] en_i,
	output logic      [NOUT-1:0] in_reg_o
);
	logic [NOUT-1:0] en_seen;
	logic [3:0]      ramp;
	logic [3:0]      next_ramp;

	// Any change of the enable pattern restarts the ramp for all rails.
	assign next_ramp = (en_i != en_seen) ? 4'h0 :
		((ramp == 4'hF) ? ramp : ramp + 4'h1);
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			en_seen <= '0;
			ramp    <= '0;
		end else begin
			en_seen <= en_i;
			ramp    <= next_ramp;
		end
	end

	// Regulation is reported only for rails that stayed enabled.
	assign in_reg_o = (ramp >= (slow_i ? 4'hC : 4'h2)) ? (en_i & en_seen) : '0;
endmodule

// file: tb/pmsc_asserts.sv
`timescale 1ns/100ps
// Watches the power states against the supply, rail and fault inputs.
module pmsc_asserts
	import pmsc_pkg::*;
#(
	parameter int RETRY_CYCLES = RETRY_CYC
) (
	input wire logic            mclk_i,
	input wire logic            rstn_i,
	input wire logic            vin_above_undervoltage_lockout_threshold_i,
	input wire logic            vin_below_ov_i,
	input wire logic [NOUT-1:0] out_in_reg_i,
	input wire logic [NOUT-1:0] out_ovuv_i,
	input wire logic [NOUT-1:0] out_en_o,
	input wire logic            buck1_bypass_o,
	input wire logic            buck4_ldo_o,
	input wire logic            ldo1_bypass_o,
	input wire logic            ldo2_switch_o,
	input wire logic            extra_delay_o,
	input wire logic [3:0]      fault_mask_o,
	input wire logic            system_reset_n_o,
	input wire logic            serial_reset_o,
	input wire logic [2:0]      state_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	logic [31:0] dwell;

	// Counts cycles spent in fault retry, so its length can be judged.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			dwell <= '0;
		else
			dwell <= (state_o == PMSC_FAULT) ? dwell + 32'h1 : '0;
	end

	a_mask_start: assert property (
		state_o inside {PMSC_COLD, PMSC_STRAP, PMSC_SEQ} |-> fault_mask_o == 4'hF)
		else $error("masks not forced in start-up");
	a_mask_clear: assert property (
		state_o == PMSC_ACTIVE |-> fault_mask_o == 4'h0)
		else $error("masks not cleared in active");
	a_cold_exit: assert property (
		state_o == PMSC_COLD && vin_above_undervoltage_lockout_threshold_i && vin_below_ov_i
		|-> ##[1:4] state_o == PMSC_STRAP) else $error("cold state not left");
	a_undervoltage_lockout_threshold_cold: assert property (
		$fell(vin_above_undervoltage_lockout_threshold_i) |-> ##[1:4] state_o == PMSC_COLD)
		else $error("lockout did not reach cold");
	a_seq_enable: assert property (
		state_o == PMSC_SEQ |-> out_en_o == 6'h3F)
		else $error("outputs not enabled in start");
	a_seq_exit: assert property (
		state_o == PMSC_SEQ && (&out_in_reg_i) && out_ovuv_i == '0
		&& vin_above_undervoltage_lockout_threshold_i |-> ##[1:4]
		state_o inside {PMSC_ACTIVE, PMSC_SLEEP, PMSC_DEEP})
		else $error("start state not left");
	a_reset_out: assert property (
		system_reset_n_o == (state_o inside {PMSC_ACTIVE, PMSC_SLEEP, PMSC_DEEP}))
		else $error("system reset level wrong");
	a_retry_dwell: assert property (
		$fell(state_o == PMSC_FAULT) && $past(rstn_i) |->
		state_o == PMSC_COLD || (dwell >= RETRY_CYCLES
		&& dwell <= RETRY_CYCLES + 1 && state_o == PMSC_ACTIVE))
		else $error("fault retry length wrong");
	a_fault_serial: assert property (
		state_o == PMSC_FAULT && $past(state_o) != PMSC_FAULT
		|-> ##[0:1] serial_reset_o) else $error("serial reset missing");
	a_strap_hold: assert property (
		state_o inside {PMSC_ACTIVE, PMSC_SLEEP, PMSC_DEEP, PMSC_FAULT}
		&& $past(state_o) != PMSC_STRAP |-> $stable({buck1_bypass_o,
		buck4_ldo_o, ldo1_bypass_o, ldo2_switch_o, extra_delay_o}))
		else $error("strap result changed");

	c_sleep: cover property (state_o == PMSC_SLEEP);
	c_deep: cover property (state_o == PMSC_DEEP);
	c_fault: cover property ($fell(state_o == PMSC_FAULT));
endmodule

bind pmsc_top pmsc_asserts #(.RETRY_CYCLES(RETRY_CYCLES)) pmsc_asserts_inst (
	.mclk_i(mclk_i), .rstn_i(rstn_i), .vin_above_undervoltage_lockout_threshold_i(vin_above_undervoltage_lockout_threshold_i),
	.vin_below_ov_i(vin_below_ov_i), .out_in_reg_i(out_in_reg_i),
	.out_ovuv_i(out_ovuv_i), .out_en_o(out_en_o),
	.buck1_bypass_o(buck1_bypass_o), .buck4_ldo_o(buck4_ldo_o),
	.ldo1_bypass_o(ldo1_bypass_o), .ldo2_switch_o(ldo2_switch_o),
	.extra_delay_o(extra_delay_o), .fault_mask_o(fault_mask_o),
	.system_reset_n_o(system_reset_n_o), .serial_reset_o(serial_reset_o),
	.state_o(state_o));

// file: tb/pmsc_top_tb.sv
`timescale 1ns/100ps
module pmsc_top_tb;
	import pmsc_pkg::*;
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
		logic       g7;
		logic [2:0] st;
	} pmsc_row_t;
	logic mclk_i, rstn_i, vin_above_undervoltage_lockout_threshold_i, vin_below_ov_i, wr_i, rd_i, slow;
	logic [5:0] out_in_reg_i, out_ovuv_i, out_en_o;
	logic [7:0] gpio_i, strap_lvl_i, addr_i, wdata_i, rdata_o, vsel_o, rd_val;
	logic [1:0] b3_sel_o;
	logic [3:0] fault_mask_o;
	logic [2:0] state_o;
	logic b3_scale_o, buck1_bypass_o, buck4_ldo_o, ldo1_bypass_o;
	logic ldo2_switch_o, extra_delay_o, system_reset_n_o, serial_reset_o;
	int miscompares, n_checks;
	pmsc_row_t rows [19];

	pmsc_top #(.RETRY_CYCLES(20)) pmsc_top_inst (.mclk_i, .rstn_i,
		.vin_above_undervoltage_lockout_threshold_i, .vin_below_ov_i, .out_in_reg_i, .out_ovuv_i,
		.gpio_i, .strap_lvl_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.out_en_o, .b3_sel_o, .b3_scale_o, .vsel_o, .buck1_bypass_o,
		.buck4_ldo_o, .ldo1_bypass_o, .ldo2_switch_o, .extra_delay_o,
		.fault_mask_o, .system_reset_n_o, .serial_reset_o, .state_o);
	pmsc_rail_model pmsc_rail_model_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.slow_i(slow), .en_i(out_en_o), .in_reg_o(out_in_reg_i));

	// Free-running 250 MHz clock.
	always #2 mclk_i = ~mclk_i;

	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Register strobes last one cycle; read data stand in the next cycle.
	task reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task reg_rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 q = rdata_o;
	endtask
	task wait_st(input logic [2:0] s, input int lim);
		int k;
		k = 0;
		while (state_o !== s && k < lim) begin
			@(posedge mclk_i);
			#1 k++;
		end
		check(state_o, s);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Watchdog sized at tens of times the expected run.
	initial begin
		#40000;
		miscompares++;
		print_verdict;
	end

	// Whole-byte writes with known neighbours, so no bit is lost.
	initial begin
		rows = '{'{1'b0,8'h00,8'h00,8'h00,1'b0,3'h3},
			'{1'b0,8'h01,8'h00,8'h3F,1'b0,3'h3}, '{1'b0,8'h02,8'h00,8'h81,1'b0,3'h3},
			'{1'b1,8'h20,8'h55,8'h00,1'b0,3'h3}, '{1'b1,8'h03,8'hFF,8'hE1,1'b0,3'h3},
			'{1'b1,8'h03,8'h80,8'h80,1'b0,3'h3}, '{1'b1,8'h04,8'h9E,8'h80,1'b0,3'h3},
			'{1'b0,8'h06,8'h00,8'h0B,1'b0,3'h3}, '{1'b1,8'h05,8'h15,8'h15,1'b0,3'h3},
			'{1'b1,8'h00,8'h01,8'h01,1'b0,3'h3}, '{1'b0,8'h00,8'h00,8'h01,1'b1,3'h4},
			'{1'b0,8'h00,8'h00,8'h01,1'b0,3'h3}, '{1'b1,8'h00,8'h04,8'h04,1'b1,3'h4},
			'{1'b1,8'h00,8'h05,8'h05,1'b0,3'h4}, '{1'b1,8'h00,8'h04,8'h04,1'b0,3'h3},
			'{1'b1,8'h00,8'h02,8'h02,1'b1,3'h5}, '{1'b1,8'h00,8'h02,8'h02,1'b0,3'h3},
			'{1'b1,8'h00,8'h0A,8'h0A,1'b0,3'h5}, '{1'b1,8'h00,8'h08,8'h08,1'b0,3'h3}};
		{mclk_i, rstn_i, wr_i, rd_i, addr_i, wdata_i, out_ovuv_i} = '0;
		{vin_above_undervoltage_lockout_threshold_i, vin_below_ov_i, slow} = 3'h7;
		gpio_i = 8'h41;
		strap_lvl_i = 8'h4A;
		repeat (20) @(posedge mclk_i);
		#1 check(fault_mask_o, 4'hF);
		check(state_o, 3'h0);
		@(posedge mclk_i);
		rstn_i <= 1'b1;
		wait_st(3'h2, 20);
		check(out_en_o, 6'h3F);
		wait_st(3'h3, 40);
		check(fault_mask_o, 4'h0);
		check({buck1_bypass_o, buck4_ldo_o, ldo1_bypass_o}, 8'h01);
		check(b3_sel_o, LVL_HIGH);
		check(vsel_o[VO_B2], 1'b0);
		check(ldo2_switch_o, 1'b1);
		check(extra_delay_o, 1'b1);
		// Moving strap pins after power-up must leave the latched result.
		@(posedge mclk_i);
		gpio_i      <= 8'h21;
		strap_lvl_i <= 8'h00;
		slow        <= 1'b0;
		repeat (6) @(posedge mclk_i);
		#1 check({ldo2_switch_o, extra_delay_o, ldo1_bypass_o}, 8'h07);
		reg_rd(8'h07, rd_val);
		check(rd_val, 8'h4A);
		foreach (rows[i]) begin
			gpio_i[7] <= rows[i].g7;
			if (rows[i].wr)
				reg_wr(rows[i].addr, rows[i].wdata);
			reg_rd(rows[i].addr, rd_val);
			check(rd_val, rows[i].exp);
			wait_st(rows[i].st, 40);
		end
		// Sleep pattern, then deep sleep winning over sleep.
		reg_wr(8'h01, 8'h4A);
		reg_wr(8'h00, 8'h01);
		gpio_i[7] <= 1'b1;
		wait_st(3'h4, 40);
		check(out_en_o & 6'h3B, 6'h0A);
		check(b3_scale_o, 1'b1);
		reg_wr(8'h00, 8'h03);
		wait_st(3'h5, 40);
		check({b3_scale_o, out_en_o}, 8'h01);
		gpio_i[7] <= 1'b0;
		wait_st(3'h3, 40);
		// A rail fault after start-up holds the retry state, then recovers.
		out_ovuv_i <= 6'h08;
		wait_st(3'h6, 40);
		check(system_reset_n_o, 1'b0);
		out_ovuv_i <= '0;
		wait_st(3'h3, 80);
		// Supply loss drops every host write; a request made during start
		// is honoured once the rails regulate.
		reg_wr(8'h00, 8'h04);
		slow <= 1'b1;
		vin_above_undervoltage_lockout_threshold_i <= 1'b0;
		wait_st(3'h0, 10);
		check(fault_mask_o, 4'hF);
		vin_above_undervoltage_lockout_threshold_i <= 1'b1;
		wait_st(3'h2, 20);
		reg_rd(8'h00, rd_val);
		check(rd_val, 8'h00);
		reg_wr(8'h00, 8'h01);
		wait_st(3'h4, 40);
		reg_rd(8'h03, rd_val);
		check(rd_val, 8'h00);
		reg_rd(8'h01, rd_val);
		check(rd_val, 8'h3F);
		print_verdict;
	end
endmodule
